// File: hw/ead_top.sv
// External address attribute decoder: four attribute registers on Wishbone,
// per-register select/row-strobe pins and DMA byte packing on the expansion port.
// Assumes requests synchronous to clk and a fixed-length external access.
//
// The Wishbone slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Each register drives own pin on match
// - Match value sits in bits 23..12
// - Compare uses address bits 23..12
// - Bits 11..8 count compared bits, top down
// - Count zero: whole enabled external space
// - Packing: three accesses at addr, +1, +2
// - Bytes ordered little-endian, low first
// - Packed bytes use data lines 7..0
// - No packing: one 24-bit access
// - Packing only for DMA accesses
// - Packed triple keeps bus, no arbitration
// - Bit 5 enables Y space compare
// - Full address driven, never multiplexed
// - Registers read/write, reset to zero
// - Bit 4 X, bit 3 program enable
// - Bit 2 clear: pin active low
// - Bits 1..0 select SRAM or DRAM
// - Unmatched accesses run as SRAM
module ead_top #(
	parameter int          ACC_CYCLES  = 2,
	parameter logic [23:0] INT_MAP_TOP = 24'h000800
) (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          wb_cyc_i,
	input  wire logic                          wb_stb_i,
	input  wire logic                          wb_we_i,
	input  wire logic [ead_pkg::WB_ADR_W-1:0]  wb_adr_i,
	input  wire logic [3:0]                    wb_sel_i,
	input  wire logic [31:0]                   wb_dat_i,
	output logic [31:0]                        wb_dat_o,
	output logic                               wb_ack_o,
	input  wire ead_pkg::ead_req_s             req,
	output logic                               req_ack,
	output logic [ead_pkg::DATA_W-1:0]         req_rdata,
	input  wire logic [ead_pkg::DATA_W-1:0]    ext_din,
	output ead_pkg::ead_ext_s                  ext,
	output logic [ead_pkg::NUM_SEL-1:0]        select_or_row_strobe_pin,
	output logic                               bus_hold
);

	localparam logic [3:0] WAIT_LOAD = 4'(ACC_CYCLES - 1);

	typedef struct packed {
		logic [ead_pkg::NUM_SEL-1:0][ead_pkg::DATA_W-1:0] cfg;
		logic                                             wb_ack;
		logic [31:0]                                      wb_dat;
		ead_pkg::ead_state_e                              st;
		logic [1:0]                                       beat;
		logic [3:0]                                       wait_cnt;
		logic                                             pack;
		logic                                             dma;
		ead_pkg::ead_space_e                              space;
		logic [ead_pkg::DATA_W-1:0]                       wdata;
		ead_pkg::ead_ext_s                                ext;
		logic [ead_pkg::NUM_SEL-1:0]                      pins;
		logic                                             hold;
		logic                                             req_ack;
		logic [ead_pkg::DATA_W-1:0]                       rdata;
	} ead_top_s;

	ead_top_s s;
	ead_top_s next_s;

	logic [ead_pkg::ADDR_W-1:0]   m_addr;
	ead_pkg::ead_space_e          m_space;
	logic [ead_pkg::NUM_SEL-1:0]  hit;
	logic [ead_pkg::NUM_SEL-1:0]  pol;
	logic [ead_pkg::NUM_SEL-1:0]  pack_en;
	logic [ead_pkg::NUM_SEL-1:0]  dram_en;
	logic [ead_pkg::NUM_SEL-1:0]  pins_on;
	logic [2:0]                   reg_idx;
	logic                         wb_req;
	logic [31:0]                  rd_mux;
	logic [1:0]                   nbeat;
	logic [ead_pkg::DATA_W-1:0]   pk_word;
	logic                         pk_capture;

	// Match the request address while idle, the next byte address while packing
	assign m_addr  = (s.st == ead_pkg::ST_IDLE) ? req.addr : s.ext.addr + 24'h1;
	assign m_space = (s.st == ead_pkg::ST_IDLE) ? req.space : s.space;
	assign nbeat   = s.beat + 2'h1;

	genvar g;
	generate
		for (g = 0; g < ead_pkg::NUM_SEL; g++) begin : g_sel
			ead_match #(
				.INT_MAP_TOP (INT_MAP_TOP)
			) u_match (
				.cfg   (s.cfg[g]),
				.addr  (m_addr),
				.space (m_space),
				.hit   (hit[g])
			);
			assign pol[g]     = s.cfg[g][ead_pkg::POL_BIT];
			assign pack_en[g] = s.cfg[g][ead_pkg::PACK_BIT];
			assign dram_en[g] = s.cfg[g][ead_pkg::TYPE_HI:ead_pkg::TYPE_LO]
				== ead_pkg::MEM_DRAM;
		end
	endgenerate

	// Polarity bit set: active high; clear: active low
	assign pins_on = ~(hit ^ pol);

	assign pk_capture = (s.st == ead_pkg::ST_ACCESS) && s.pack && !s.ext.write
		&& (s.wait_cnt == '0);

	ead_packer u_packer (
		.clk     (clk),
		.rstn    (rstn),
		.capture (pk_capture),
		.beat    (s.beat),
		.din     (ext_din[ead_pkg::BYTE_W-1:0]),
		.word    (pk_word)
	);

	// Register port
	assign reg_idx = wb_adr_i[4:2];
	assign wb_req  = wb_cyc_i && wb_stb_i;

	always_comb begin
		rd_mux = '0;
		if (reg_idx <= ead_pkg::REG_CFG_LAST) begin
			rd_mux = {8'h00, s.cfg[reg_idx[1:0]]};
		end else if (reg_idx == ead_pkg::REG_STATUS) begin
			rd_mux = {23'h000000, s.pack, s.pins, s.beat, s.hold, s.ext.active};
		end
	end

	always_comb begin
		next_s = s;
		next_s.req_ack = 1'b0;

		// Ack one cycle after the strobe, drop it the cycle after
		next_s.wb_ack = wb_req && !s.wb_ack;
		next_s.wb_dat = (wb_req && !s.wb_ack) ? rd_mux : 32'h00000000;
		if (wb_req && wb_we_i && s.wb_ack && (reg_idx <= ead_pkg::REG_CFG_LAST)) begin
			for (int b = 0; b < 3; b++) begin
				if (wb_sel_i[b]) begin
					next_s.cfg[reg_idx[1:0]][b*ead_pkg::BYTE_W +: ead_pkg::BYTE_W] =
						wb_dat_i[b*ead_pkg::BYTE_W +: ead_pkg::BYTE_W]
						& ead_pkg::CFG_WMASK[b*ead_pkg::BYTE_W +: ead_pkg::BYTE_W];
				end
			end
		end

		case (s.st)
			ead_pkg::ST_IDLE: begin
				if (req.valid && !s.req_ack) begin
					next_s.st       = ead_pkg::ST_ACCESS;
					next_s.pack     = req.dma && ((hit & pack_en) != '0);
					next_s.dma      = req.dma;
					next_s.space    = req.space;
					next_s.wdata    = req.wdata;
					next_s.beat     = ead_pkg::FIRST_BEAT;
					next_s.wait_cnt = WAIT_LOAD;
					next_s.hold     = 1'b1;
					next_s.ext.active = 1'b1;
					next_s.ext.write  = req.write;
					next_s.ext.doe    = req.write;
					next_s.ext.addr   = req.addr;
					next_s.ext.dram   = (hit & dram_en) != '0;
					next_s.pins       = pins_on;
					if (next_s.pack) begin
						next_s.ext.dout = {16'h0000, req.wdata[ead_pkg::BYTE_W-1:0]};
					end else begin
						next_s.ext.dout = req.wdata;
					end
				end
			end
			ead_pkg::ST_ACCESS: begin
				if (s.wait_cnt != '0) begin
					next_s.wait_cnt = s.wait_cnt - 4'h1;
				end else if (s.pack && (s.beat != ead_pkg::LAST_BEAT)) begin
					// Next byte at the following address, match taken afresh
					next_s.beat     = nbeat;
					next_s.wait_cnt = WAIT_LOAD;
					next_s.ext.addr = m_addr;
					next_s.ext.dram = (hit & dram_en) != '0;
					next_s.pins     = pins_on;
					next_s.ext.dout = {16'h0000,
						s.wdata[nbeat*ead_pkg::BYTE_W +: ead_pkg::BYTE_W]};
				end else begin
					next_s.st         = ead_pkg::ST_IDLE;
					next_s.hold       = 1'b0;
					next_s.req_ack    = 1'b1;
					next_s.ext.active = 1'b0;
					next_s.ext.doe    = 1'b0;
					next_s.ext.write  = 1'b0;
					next_s.ext.dram   = 1'b0;
					next_s.pins       = ~pol;
					next_s.pack       = 1'b0;
					if (s.pack) begin
						next_s.rdata = {ext_din[ead_pkg::BYTE_W-1:0],
							pk_word[2*ead_pkg::BYTE_W-1:0]};
					end else begin
						next_s.rdata = ext_din;
					end
				end
			end
			default: begin
				next_s.st = ead_pkg::ST_IDLE;
			end
		endcase

		// Idle pins take the polarity being written, so a polarity write never
		// shows one cycle of an active pin while no access is running
		if (!next_s.ext.active) begin
			for (int p = 0; p < ead_pkg::NUM_SEL; p++) begin
				next_s.pins[p] = ~next_s.cfg[p][ead_pkg::POL_BIT];
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s      <= '0;
			s.cfg  <= {ead_pkg::NUM_SEL{ead_pkg::CFG_RESET}};
			s.st   <= ead_pkg::ST_IDLE;
			s.pins <= '1;
		end else begin
			s <= next_s;
		end
	end

	assign wb_ack_o                 = s.wb_ack;
	assign wb_dat_o                 = s.wb_dat;
	assign req_ack                  = s.req_ack;
	assign req_rdata                = s.rdata;
	assign ext                      = s.ext;
	assign select_or_row_strobe_pin = s.pins;
	assign bus_hold                 = s.hold;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_pin_idle;
		!s.ext.active |-> (s.pins == ~pol);
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin active with no access");

	property p_addr_direct;
		$rose(s.ext.active) |-> (s.ext.addr == $past(req.addr));
	endproperty
	a_addr_direct: assert property (p_addr_direct) else $error("start address not direct");

	property p_pack_step;
		(s.ext.active && s.pack && (s.beat != $past(s.beat)) && $past(s.ext.active))
			|-> (s.ext.addr == $past(s.ext.addr) + 24'h1);
	endproperty
	a_pack_step: assert property (p_pack_step) else $error("packed address did not step");

	property p_pack_lanes;
		(s.ext.active && s.pack) |-> (s.ext.dout[ead_pkg::DATA_W-1:ead_pkg::BYTE_W] == '0);
	endproperty
	a_pack_lanes: assert property (p_pack_lanes) else $error("packed byte off low lanes");

	property p_core_no_pack;
		(s.ext.active && !s.dma) |-> (!s.pack && (s.beat == ead_pkg::FIRST_BEAT));
	endproperty
	a_core_no_pack: assert property (p_core_no_pack) else $error("core access was packed");

	property p_hold;
		(s.ext.active && s.pack) |-> ##1 (s.hold || s.req_ack);
	endproperty
	a_hold: assert property (p_hold) else $error("bus released inside packed access");

	property p_single;
		($rose(s.ext.active) && !s.pack) |-> ##[1:16] (s.req_ack && (s.beat == ead_pkg::FIRST_BEAT));
	endproperty
	a_single: assert property (p_single) else $error("unpacked access not single");

	property p_pack_three;
		($rose(s.ext.active) && s.pack) |-> ##[1:48] (s.req_ack && (s.beat == ead_pkg::LAST_BEAT));
	endproperty
	a_pack_three: assert property (p_pack_three) else $error("packed access not three beats");

	property p_wb_ack;
		s.wb_ack |=> !s.wb_ack;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("ack held two cycles");

endmodule

`default_nettype wire

// File: hw/ead_pkg.sv
// Shared constants and carrier types for the external address attribute decoder.
// Assumes a 24-bit external address and data bus and a 32-bit Wishbone register port.
package ead_pkg;

	localparam int NUM_SEL = 4;
	localparam int ADDR_W  = 24;
	localparam int DATA_W  = 24;
	localparam int BYTE_W  = 8;
	localparam int WB_ADR_W = 5;

	// Attribute register field layout
	localparam int MATCH_VALUE_HI = 23;
	localparam int MATCH_VALUE_LO = 12;
	localparam int MATCH_BITS     = 12;
	localparam int COUNT_HI       = 11;
	localparam int COUNT_LO       = 8;
	localparam int PACK_BIT       = 7;
	localparam int Y_BIT          = 5;
	localparam int X_BIT          = 4;
	localparam int P_BIT          = 3;
	localparam int POL_BIT        = 2;
	localparam int TYPE_HI        = 1;
	localparam int TYPE_LO        = 0;

	localparam logic [DATA_W-1:0] CFG_RESET = 24'h000000;
	// Bit 6 is reserved: never stored, reads as zero
	localparam logic [DATA_W-1:0] CFG_WMASK = 24'hffffbf;
	localparam logic [3:0]        COUNT_ALL_SPACE = 4'h0;
	localparam logic [1:0]        MEM_SRAM = 2'h1;
	localparam logic [1:0]        MEM_DRAM = 2'h2;

	// Register word indices (byte address = index * 4)
	localparam logic [2:0] REG_CFG_LAST = 3'h3;
	localparam logic [2:0] REG_STATUS   = 3'h4;

	// Byte packing
	localparam logic [1:0] LAST_BEAT  = 2'h2;
	localparam logic [1:0] FIRST_BEAT = 2'h0;

	typedef enum logic [1:0] {
		SPACE_X,
		SPACE_Y,
		SPACE_P
	} ead_space_e;

	typedef enum logic {
		ST_IDLE,
		ST_ACCESS
	} ead_state_e;

	// Access request from the core or the DMA engine
	typedef struct packed {
		logic                valid;
		logic                write;
		logic                dma;
		ead_space_e          space;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   wdata;
	} ead_req_s;

	// External expansion bus drive
	typedef struct packed {
		logic                active;
		logic                write;
		logic                dram;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dout;
		logic                doe;
	} ead_ext_s;

endpackage

// File: hw/ead_match.sv
// Address match for one attribute register.
// Purely combinational; the caller registers the resulting pin level.
`timescale 1ns/1ps
`default_nettype none

module ead_match #(
	parameter logic [23:0] INT_MAP_TOP = 24'h000800
) (
	input  wire logic [ead_pkg::DATA_W-1:0] cfg,
	input  wire logic [ead_pkg::ADDR_W-1:0] addr,
	input  wire ead_pkg::ead_space_e        space,
	output logic                            hit
);

	logic [ead_pkg::MATCH_BITS-1:0] mask;
	logic [ead_pkg::MATCH_BITS-1:0] value;
	logic [3:0]                     count;
	logic                           space_ok;

	assign value = cfg[ead_pkg::MATCH_VALUE_HI:ead_pkg::MATCH_VALUE_LO];
	assign count = cfg[ead_pkg::COUNT_HI:ead_pkg::COUNT_LO];

	// Compare bits are taken from the top down
	genvar g;
	generate
		for (g = 0; g < ead_pkg::MATCH_BITS; g++) begin : g_mask
			assign mask[g] = ({1'b0, count} + 5'(g)) >= 5'(ead_pkg::MATCH_BITS);
		end
	endgenerate

	always_comb begin
		case (space)
			ead_pkg::SPACE_Y: space_ok = cfg[ead_pkg::Y_BIT];
			ead_pkg::SPACE_X: space_ok = cfg[ead_pkg::X_BIT];
			ead_pkg::SPACE_P: space_ok = cfg[ead_pkg::P_BIT];
			default:          space_ok = 1'b0;
		endcase
		// Count zero takes all space from INT_MAP_TOP up; else top-bit compare
		if (count == ead_pkg::COUNT_ALL_SPACE) begin
			hit = space_ok && (addr >= INT_MAP_TOP);
		end else begin
			hit = space_ok && (((addr[ead_pkg::ADDR_W-1 -: ead_pkg::MATCH_BITS] ^ value)
				& mask) == '0);
		end
	end

endmodule

`default_nettype wire

// File: hw/ead_packer.sv
// Little-endian assembly of three external bytes into one 24-bit word.
// Expects capture only while a packed read beat ends.
`timescale 1ns/1ps
`default_nettype none

module ead_packer (
	input  wire logic                          clk,
	input  wire logic                          rstn,
	input  wire logic                          capture,
	input  wire logic [1:0]                    beat,
	input  wire logic [ead_pkg::BYTE_W-1:0]    din,
	output logic [ead_pkg::DATA_W-1:0]         word
);

	typedef struct packed {
		logic [ead_pkg::DATA_W-1:0] word;
	} ead_pk_s;

	ead_pk_s s;
	ead_pk_s next_s;

	always_comb begin
		next_s = s;
		if (capture) begin
			next_s.word[beat*ead_pkg::BYTE_W +: ead_pkg::BYTE_W] = din;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign word = s.word;

endmodule

`default_nettype wire

// File: verif/ead_ext_mem.sv
// External memory model on the expansion port: 256 words, low address byte used.
// Assumes the decoder drives ext registered on clk.
`timescale 1ns/1ps
`default_nettype none
module ead_ext_mem (
	input  wire logic              clk,
	input  wire ead_pkg::ead_ext_s ext,
	output logic [23:0]            ext_din
);
	logic [23:0] mem [256];
	logic [23:0] last;
	logic        rd;
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = {3{i[7:0]}} ^ 24'h5a3c96;
		end
		last = 24'h0;
	end
	assign rd = ext.active && !ext.write;
	// Released bus shows the inverse of the last word, never a held value
	assign ext_din = rd ? mem[ext.addr[7:0]] : ~last;
	always @(posedge clk) begin
		if (rd) begin
			last <= mem[ext.addr[7:0]];
		end
		if (ext.active && ext.write) begin
			mem[ext.addr[7:0]] <= ext.dout;
		end
	end
endmodule
`default_nettype wire

// File: verif/test_external_address_attribute_decoder.sv
// Self-checking bench: Wishbone register tasks, access requests with queued
// expectations, monitors comparing beats, read words and register reads.
// Assumes ead_top with ACC_CYCLES=2 and the ead_ext_mem model.
`timescale 1ns/1ps
`default_nettype none
module test_external_address_attribute_decoder;
	typedef struct packed {
		logic [23:0] a;
		logic [3:0]  p;
		logic        d;
		logic        w;
		logic [23:0] o;
	} ead_beat_s;
	logic              clk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
	logic [4:0]        adr = '0;
	logic [3:0]        sel = '0;
	logic [31:0]       wdat = '0, wb_dat_o, r;
	logic              wb_ack_o, req_ack, bus_hold, act_q = 0;
	logic [23:0]       req_rdata, ext_din, adr_q = '0;
	ead_pkg::ead_req_s req = '0;
	ead_pkg::ead_ext_s ext;
	logic [3:0]        pins;
	logic [23:0]       cfg [4], xm [256];
	logic [23:0]       tv [4] = '{24'h123c11, 24'h00002d, 24'h80019a, 24'h450339};
	logic [11:0]       tops [4] = '{12'h123, 12'h450, 12'h800, 12'h000};
	logic [31:0]       q_wb [$];
	logic [23:0]       q_rd [$];
	ead_beat_s         q_bt [$];
	ead_beat_s         eb;
	int                n_fail = 0, num_checks = 0, ncyc = 0, seed = 17373;
	always #4 clk = ~clk;
	ead_top #(.ACC_CYCLES(2)) dut (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .req(req), .req_ack(req_ack), .req_rdata(req_rdata),
		.ext_din(ext_din), .ext(ext), .select_or_row_strobe_pin(pins), .bus_hold(bus_hold));
	ead_ext_mem mem (.clk(clk), .ext(ext), .ext_din(ext_din));
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp, input string m);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic cmp_beat(input ead_beat_s g, input ead_beat_s e);
		if (!e.w) begin
			g.o = e.o;
		end
		cmp_word({4'h0, g.a, g.p}, {4'h0, e.a, e.p}, "beat address or pins");
		cmp_word({7'h0, g.d, g.o}, {7'h0, e.d, e.o}, "beat type or data");
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic wb(input logic w, input logic [2:0] i, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		logic [3:0] ip;
		if (w && i < 4) begin
			for (int b = 0; b < 3; b++) begin
				if (s[b]) cfg[i][8*b +: 8] = d[8*b +: 8] & ead_pkg::CFG_WMASK[8*b +: 8];
			end
		end
		// Status is read only while idle and before any packed access
		for (int k = 0; k < 4; k++) ip[k] = ~cfg[k][2];
		if (!w) begin
			q_wb.push_back(i < 4 ? {8'h0, cfg[i]} : i == 4 ? {24'h0, ip, 4'h0} : 32'h0);
		end
		@(posedge clk);
		cyc <= 1;
		stb <= 1;
		we <= w;
		sel <= s;
		adr <= {i, 2'b00};
		wdat <= d;
		do @(posedge clk); while (wb_ack_o !== 1'b1);
		cyc <= 0;
		stb <= 0;
	endtask
	function automatic logic hit(input int k, input logic [1:0] sp, input logic [23:0] a);
		int n;
		n = cfg[k][11:8] > 12 ? 12 : int'(cfg[k][11:8]);
		if (!cfg[k][sp == 0 ? 4 : sp == 1 ? 5 : 3]) return 0;
		if (n == 0) return a >= 24'h000800;
		return ((a ^ cfg[k]) & ~(24'hffffff >> n)) == 0;
	endfunction
	task automatic acc(input logic w, input logic dm, input logic [1:0] sp,
		input logic [23:0] a, input logic [23:0] d);
		ead_beat_s  b;
		logic       pk;
		logic [3:0] ip;
		pk = 0;
		for (int k = 0; k < 4; k++) pk |= dm & hit(k, sp, a) & cfg[k][7];
		if (!w) begin
			q_rd.push_back(pk ? {xm[a[7:0] + 8'h2][7:0], xm[a[7:0] + 8'h1][7:0],
				xm[a[7:0]][7:0]} : xm[a[7:0]]);
		end
		for (int j = 0; j < (pk ? 3 : 1); j++) begin
			b.a = a + j;
			b.w = w;
			b.d = 0;
			for (int k = 0; k < 4; k++) begin
				b.p[k] = hit(k, sp, b.a) ~^ cfg[k][2];
				b.d |= hit(k, sp, b.a) & (cfg[k][1:0] == 2'h2);
			end
			b.o = pk ? {16'h0, d[8*j +: 8]} : d;
			if (w) xm[b.a[7:0]] = b.o;
			q_bt.push_back(b);
		end
		@(posedge clk);
		req <= '{1'b1, w, dm, ead_pkg::ead_space_e'(sp), a, d};
		do @(posedge clk); while (req_ack !== 1'b1);
		req.valid <= 1'b0;
		for (int k = 0; k < 4; k++) ip[k] = ~cfg[k][2];
		cmp_word(pins, ip, "idle pins");
	endtask
	always @(posedge clk) begin
		ncyc++;
		if (ext.active && (!act_q || ext.addr != adr_q)) begin
			eb = q_bt.pop_front();
			cmp_beat('{ext.addr, pins, ext.dram, ext.write, ext.dout}, eb);
			cmp_word(ext.doe, eb.w, "data enable");
			cmp_word(bus_hold, 1, "bus hold");
		end
		if (req_ack && !req.write) cmp_word(req_rdata, q_rd.pop_front(), "read word");
		if (wb_ack_o && !we) cmp_word(wb_dat_o, q_wb.pop_front(), "reg read");
		act_q <= ext.active;
		adr_q <= ext.addr;
		if (ncyc > 5000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		for (int i = 0; i < 256; i++) xm[i] = {3{i[7:0]}} ^ 24'h5a3c96;
		for (int i = 0; i < 4; i++) cfg[i] = 24'h0;
		repeat (10) @(posedge clk);
		rstn <= 1;
		cmp_word(pins, 4'hf, "reset pins");
		for (int i = 0; i < 8; i++) wb(0, i, 0);
		wb(1, 0, 32'hffffffff);
		wb(1, 0, 32'h00000000, 4'h2);
		wb(0, 4, 0);
		wb(1, 6, 32'h123);
		wb(0, 0, 0);
		wb(0, 6, 0);
		for (int i = 0; i < 4; i++) wb(1, i, tv[i]);
		for (int i = 0; i < 4; i++) wb(0, i, 0);
		$display("register test done");
		acc(1, 0, 0, 24'h123456, 24'h0badf0);
		acc(0, 0, 0, 24'h123456, 0);
		acc(1, 0, 1, 24'h123457, 24'h111111);
		acc(0, 0, 2, 24'h000100, 0);
		acc(0, 0, 2, 24'h450010, 0);
		acc(1, 1, 0, 24'h800030, 24'ha1b2c3);
		acc(0, 1, 0, 24'h800030, 0);
		acc(0, 1, 0, 24'h800033, 0);
		acc(1, 0, 0, 24'h800036, 24'h445566);
		acc(1, 1, 1, 24'h800040, 24'h778899);
		$display("decode test done");
		for (int k = 0; k < 24; k++) begin
			r = $random(seed);
			if (k == 12) wb(1, 0, 24'h123c15);
			acc(r[0], r[1], r[3:2] == 2'h3 ? 2'h1 : r[3:2], {tops[r[5:4]], 4'h0, r[15:8]},
				r[31:8]);
		end
		$display("random test done");
		repeat (4) @(posedge clk);
		cmp_word(q_bt.size() + q_rd.size() + q_wb.size(), 0, "results left over");
		finish_test();
	end
endmodule
`default_nettype wire
